// file: include/scp_pkg.sv
package scp_pkg;
   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_CFG = 8'h00; // Port configuration byte.
   localparam logic [7:0] ADDR_CHIP_ID = 8'h01; // Chip identity, read only.
   localparam logic [7:0] ADDR_CHIP_GRADE = 8'h02; // Chip grade, read only.
   localparam logic [7:0] ADDR_DEV_INDEX = 8'h05; // Device index register.
   localparam logic [7:0] ADDR_DEV_UPDATE = 8'hFF; // Transfer register.
   localparam logic [7:0] ADDR_FUNC_LO = 8'h08; // First converter function register.
   localparam logic [7:0] ADDR_FUNC_HI = 8'h22; // Last converter function register.
   localparam int FUNC_COUNT = 27; // Number of function registers.
   // ----------------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------------
   localparam logic [7:0] PORT_CFG_RST = 8'h18; // Port configuration default.
   localparam logic [7:0] PORT_CFG_ONES = 8'h18; // Bits that always read one.
   localparam logic [7:0] DEV_INDEX_RST = 8'h0F; // Device index default.
   localparam logic [7:0] DEV_UPDATE_RST = 8'h00; // Transfer default.
   localparam logic [7:0] FUNC_RST = 8'h00; // Function register default.
   localparam logic [7:0] CHIP_ID_VAL = 8'hA5; // Arbitrary identity value.
   localparam logic [7:0] CHIP_GRADE_VAL = 8'h40; // Arbitrary grade value.
   localparam int BIT_LSB_A = 6; // Bit-order control, upper copy.
   localparam int BIT_LSB_B = 1; // Bit-order lower copy; stored, but bit order follows bit 6 only.
   localparam int BIT_SRST_A = 5; // Soft-reset control, upper copy.
   localparam int BIT_SRST_B = 2; // Soft-reset control, lower copy.
   localparam int INSTR_BITS = 16; // Instruction length.
   localparam int INSTR_RW = 15; // Read flag within the instruction.
   localparam int INSTR_W1 = 14; // Word length bit one.
   localparam int INSTR_W0 = 13; // Word length bit zero.
   // ----------------------------------------------------------------------
   // Serial sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_INSTR = 2'b01,
      ST_DATA = 2'b11
   } scp_state_type;
endpackage

// file: hw/scp_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser with edge detection on the settled stage.
module scp_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic d,
   input wire logic rst_val,
   output logic q,
   output logic rise,
   output logic fall
);
   logic s1_r; // First stage, read only by the second.
   logic s2_r; // Settled level.
   logic s3_r; // Previous settled level for edges.
   // Async reset loads a constant; the pin's idle level is then taken in.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign q = s2_r;
   assign rise = s2_r & ~s3_r & ~rst_val;
   assign fall = ~s2_r & s3_r & ~rst_val;
endmodule

// file: hw/scp_top.sv
`timescale 1ns/1ps
// How it works
// - Chip select and clock are inputs only.
// - Data pin receives on writes, drives reads.
// - Select high at power-up selects strap mode.
// - Incoming bits sampled on rising clock edge.
// - Drive after falling edge, release after rising.
// - Chip configuration at 0x00 to 0x02.
// - Index/transfer at 0x05, 0xFF; functions 0x08-0x22.
// - Reset loads every register's default.
// - Mirrored control bits, but bit order follows bit 6 only; bits 4,3 read one.
// - Sixteen-bit instruction, then word-length counted bytes.
// - Word length 11 streams until select rises.
// - Select rising mid-byte restarts the sequencer.
// - Most significant bit first after power-up.
module scp_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic serial_clock_pattern_strap,
   input wire logic serial_data_powerdown_strap_i,
   output logic serial_data_powerdown_strap_o,
   output logic serial_data_powerdown_strap_oe,
   output logic strap_mode,
   output logic strap_pattern,
   output logic strap_powerdown,
   output logic [7:0] dev_index,
   output logic update_pulse,
   output logic lsb_first
);
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic cs_q; // Settled chip select, inputs only.
   logic cs_rise; // Chip select end of frame.
   logic cs_fall; // Chip select start of frame.
   logic sck_q; // Settled serial clock.
   logic sck_rise; // Rising serial clock edge.
   logic sck_fall; // Falling serial clock edge.
   logic sdi_q; // Settled incoming data.
   logic boot_r; // High until the first settled cycle after reset.
   scp_sync u_cs (.clk(clk), .rst_n(rst_n), .d(chip_select_n), .rst_val(boot_r),
      .q(cs_q), .rise(cs_rise), .fall(cs_fall));
   scp_sync u_sck (.clk(clk), .rst_n(rst_n), .d(serial_clock_pattern_strap), .rst_val(boot_r),
      .q(sck_q), .rise(sck_rise), .fall(sck_fall));
   scp_sync u_sdi (.clk(clk), .rst_n(rst_n), .d(serial_data_powerdown_strap_i), .rst_val(boot_r),
      .q(sdi_q), .rise(), .fall());
   // ----------------------------------------------------------------------
   // Power-up strap capture
   // ----------------------------------------------------------------------
   logic [1:0] boot_cnt_r; // Waits for the synchronisers to fill.
   // The strap is caught by a clocked process once the pins have settled.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_cnt_r <= 2'd0;
         boot_r <= 1'b1;
         strap_mode <= 1'b0;
      end else if (boot_r) begin
         boot_cnt_r <= boot_cnt_r + 2'd1;
         if (boot_cnt_r == 2'd3) begin
            boot_r <= 1'b0;
            strap_mode <= cs_q;
         end
      end
   end
   // Strap outputs follow the shared pins while in strap mode.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_pattern <= 1'b0;
         strap_powerdown <= 1'b0;
      end else begin
         strap_pattern <= strap_mode & sck_q;
         strap_powerdown <= strap_mode & sdi_q;
      end
   end
   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   logic [7:0] port_cfg_r; // Port configuration, mirrored bits.
   logic [7:0] dev_index_r; // Device index.
   logic [7:0] func_r [scp_pkg::FUNC_COUNT]; // Converter function bytes.
   logic wr_en; // A complete write byte is ready.
   logic soft_rst; // Soft reset requested by a write.
   logic [7:0] wr_addr; // Address of the byte written.
   logic [7:0] wr_byte; // Byte written.
   logic [7:0] rd_addr; // Address of the byte to read.
   logic [7:0] rd_byte; // Read mux result.
   assign soft_rst = port_cfg_r[scp_pkg::BIT_SRST_A] | port_cfg_r[scp_pkg::BIT_SRST_B];
   // Function-space decode, shared by the read and write paths.
   function automatic logic in_func(input logic [7:0] a);
      in_func = (a >= scp_pkg::ADDR_FUNC_LO) && (a <= scp_pkg::ADDR_FUNC_HI);
   endfunction
   // Port configuration: soft-reset bits self-clear the cycle after they take effect.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_cfg_r <= scp_pkg::PORT_CFG_RST;
      end else if (soft_rst) begin
         port_cfg_r <= scp_pkg::PORT_CFG_RST;
      end else if (wr_en && wr_addr == scp_pkg::ADDR_PORT_CFG) begin
         port_cfg_r <= (wr_byte & 8'h66) | scp_pkg::PORT_CFG_ONES;
      end
   end
   // Index, transfer and function registers.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_index_r <= scp_pkg::DEV_INDEX_RST;
         update_pulse <= 1'b0;
         for (int i = 0; i < scp_pkg::FUNC_COUNT; i++) begin
            func_r[i] <= scp_pkg::FUNC_RST;
         end
      end else if (soft_rst) begin
         dev_index_r <= scp_pkg::DEV_INDEX_RST;
         update_pulse <= 1'b0;
         for (int i = 0; i < scp_pkg::FUNC_COUNT; i++) begin
            func_r[i] <= scp_pkg::FUNC_RST;
         end
      end else begin
         // The transfer bit is a strobe; it never stores.
         update_pulse <= wr_en && wr_addr == scp_pkg::ADDR_DEV_UPDATE && wr_byte[0];
         if (wr_en && wr_addr == scp_pkg::ADDR_DEV_INDEX) begin
            dev_index_r <= wr_byte;
         end
         if (wr_en && in_func(wr_addr)) begin
            func_r[5'(wr_addr - scp_pkg::ADDR_FUNC_LO)] <= wr_byte;
         end
      end
   end
   // Read mux; unmapped addresses read zero.
   always_comb begin
      rd_byte = 8'h00;
      case (rd_addr)
         scp_pkg::ADDR_PORT_CFG: rd_byte = port_cfg_r;
         scp_pkg::ADDR_CHIP_ID: rd_byte = scp_pkg::CHIP_ID_VAL;
         scp_pkg::ADDR_CHIP_GRADE: rd_byte = scp_pkg::CHIP_GRADE_VAL;
         scp_pkg::ADDR_DEV_INDEX: rd_byte = dev_index_r;
         scp_pkg::ADDR_DEV_UPDATE: rd_byte = scp_pkg::DEV_UPDATE_RST;
         default: begin
            if (in_func(rd_addr)) begin
               rd_byte = func_r[5'(rd_addr - scp_pkg::ADDR_FUNC_LO)];
            end
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_index <= scp_pkg::DEV_INDEX_RST;
         lsb_first <= 1'b0;
      end else begin
         dev_index <= dev_index_r;
         lsb_first <= port_cfg_r[scp_pkg::BIT_LSB_A];
      end
   end
   // ----------------------------------------------------------------------
   // Serial sequencer
   // ----------------------------------------------------------------------
   scp_pkg::scp_state_type state_r; // Frame phase.
   logic [15:0] sh_r; // Instruction or data shift register.
   logic [3:0] bit_cnt_r; // Bits received in the current unit.
   logic rd_r; // Frame is a readback.
   logic [1:0] len_r; // Word length field.
   logic [1:0] byte_cnt_r; // Bytes done in a counted frame.
   logic [7:0] addr_r; // Current register address.
   logic [7:0] tx_r; // Byte being shifted out.
   logic lsb_mode; // Shift order in effect.
   logic [15:0] instr_word; // Instruction as assembled.
   logic [7:0] data_word; // Data byte as assembled.
   logic active; // Port is in a frame.
   assign lsb_mode = port_cfg_r[scp_pkg::BIT_LSB_A];
   assign active = ~strap_mode & ~boot_r & ~cs_q;
   assign rd_addr = addr_r;
   // Least-first frames arrive reversed; flip the whole word.
   function automatic logic [15:0] order16(input logic [15:0] v, input logic lsb);
      logic [15:0] r; // Bit-reversed copy; a stream may only feed an assignment.
      r = {<<{v}};
      order16 = lsb ? r : v;
   endfunction
   assign instr_word = order16({sh_r[14:0], sdi_q}, lsb_mode);
   // The low byte of the assembled word lands in the upper half once it is reversed.
   assign data_word = lsb_mode ? instr_word[15:8] : instr_word[7:0];
   assign wr_byte = data_word;
   assign wr_addr = addr_r;
   assign wr_en = active && state_r == scp_pkg::ST_DATA && !rd_r && sck_rise && bit_cnt_r == 4'd7;
   // Bits shift on rising serial clock edges only; idle moves to the instruction phase without one.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= scp_pkg::ST_IDLE;
         sh_r <= 16'h0000;
         bit_cnt_r <= 4'd0;
         rd_r <= 1'b0;
         len_r <= 2'd0;
         byte_cnt_r <= 2'd0;
         addr_r <= 8'h00;
      end else if (!active || cs_rise) begin
         state_r <= scp_pkg::ST_IDLE;
         bit_cnt_r <= 4'd0;
      end else begin
         case (state_r)
            scp_pkg::ST_IDLE: begin
               state_r <= scp_pkg::ST_INSTR;
               bit_cnt_r <= 4'd0;
            end
            scp_pkg::ST_INSTR: begin
               if (sck_rise) begin
                  sh_r <= {sh_r[14:0], sdi_q};
                  bit_cnt_r <= bit_cnt_r + 4'd1;
                  if (bit_cnt_r == 4'(scp_pkg::INSTR_BITS - 1)) begin
                     state_r <= scp_pkg::ST_DATA;
                     bit_cnt_r <= 4'd0;
                     byte_cnt_r <= 2'd0;
                     rd_r <= instr_word[scp_pkg::INSTR_RW];
                     len_r <= {instr_word[scp_pkg::INSTR_W1], instr_word[scp_pkg::INSTR_W0]};
                     addr_r <= instr_word[7:0];
                  end
               end
            end
            scp_pkg::ST_DATA: begin
               if (sck_rise) begin
                  sh_r <= {sh_r[14:0], sdi_q};
                  bit_cnt_r <= bit_cnt_r + 4'd1;
                  if (bit_cnt_r == 4'd7) begin
                     bit_cnt_r <= 4'd0;
                     addr_r <= lsb_mode ? addr_r + 8'd1 : addr_r - 8'd1;
                     byte_cnt_r <= byte_cnt_r + 2'd1;
                     if (len_r != 2'b11 && byte_cnt_r == len_r) begin
                        state_r <= scp_pkg::ST_INSTR;
                     end
                     // Length 11 never ends here; only select rising does.
                  end
               end
            end
            default: state_r <= scp_pkg::ST_IDLE;
         endcase
      end
   end
   // ----------------------------------------------------------------------
   // Readback driver
   // ----------------------------------------------------------------------
   logic rd_phase; // Frame is in a readback byte.
   assign rd_phase = active && state_r == scp_pkg::ST_DATA && rd_r;
   // Enable rises on a falling edge and drops on a rising edge that ends the read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_data_powerdown_strap_oe <= 1'b0;
         serial_data_powerdown_strap_o <= 1'b0;
         tx_r <= 8'h00;
      end else if (!rd_phase || cs_rise) begin
         serial_data_powerdown_strap_oe <= 1'b0;
      end else if (sck_fall) begin
         serial_data_powerdown_strap_oe <= 1'b1;
         if (bit_cnt_r == 4'd0) begin
            tx_r <= lsb_mode ? {rd_byte[0], rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
            serial_data_powerdown_strap_o <= lsb_mode ? rd_byte[0] : rd_byte[7];
         end else begin
            tx_r <= lsb_mode ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
            serial_data_powerdown_strap_o <= lsb_mode ? tx_r[0] : tx_r[7];
         end
      end else if (sck_rise && bit_cnt_r == 4'd7 && len_r != 2'b11 && byte_cnt_r == len_r) begin
         serial_data_powerdown_strap_oe <= 1'b0;
      end
   end
   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   property p_oe_only_read;
      @(posedge clk) disable iff (!rst_n) serial_data_powerdown_strap_oe |-> $past(rd_r);
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("Data pin driven outside a read.");
   property p_oe_on_fall;
      @(posedge clk) disable iff (!rst_n) $rose(serial_data_powerdown_strap_oe) |-> $past(sck_fall);
   endproperty
   a_oe_on_fall: assert property (p_oe_on_fall) else $error("Drive began off a falling edge.");
   property p_ones;
      @(posedge clk) disable iff (!rst_n) port_cfg_r[4:3] == 2'b11;
   endproperty
   a_ones: assert property (p_ones) else $error("Port bits 4 and 3 not one.");
   property p_srst_clear;
      @(posedge clk) disable iff (!rst_n) soft_rst |=> !soft_rst && dev_index_r == scp_pkg::DEV_INDEX_RST;
   endproperty
   a_srst_clear: assert property (p_srst_clear) else $error("Soft reset did not self-clear.");
   property p_cs_abort;
      @(posedge clk) disable iff (!rst_n) cs_rise |=> state_r == scp_pkg::ST_IDLE;
   endproperty
   a_cs_abort: assert property (p_cs_abort) else $error("Select rise did not restart.");
   property p_strap_quiet;
      @(posedge clk) disable iff (!rst_n) strap_mode |-> !wr_en && !serial_data_powerdown_strap_oe;
   endproperty
   a_strap_quiet: assert property (p_strap_quiet) else $error("Serial activity in strap mode.");
   property p_wr_rise;
      @(posedge clk) disable iff (!rst_n) wr_en |-> sck_rise;
   endproperty
   a_wr_rise: assert property (p_wr_rise) else $error("Write off a rising edge.");
   property p_stream;
      @(posedge clk) disable iff (!rst_n)
         (state_r == scp_pkg::ST_DATA && len_r == 2'b11 && active && !cs_rise) |=> state_r == scp_pkg::ST_DATA;
   endproperty
   a_stream: assert property (p_stream) else $error("Streaming frame ended early.");
endmodule

// file: dv/scp_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Serial controller model
// ----------------------------------------------------------------------
// Behavioural controller. The serial clock stands low between frames.
module scp_host (
   input wire logic sd_line,
   input wire logic dev_oe,
   output logic cs_n,
   output logic sclk,
   output logic sd_o,
   output logic sd_en
);
   logic [7:0] tx [4]; // Bytes to send.
   logic [7:0] rx [4]; // Bytes sampled back.
   int oe_bad = 0; // Wrong pin directions seen at capture edges.
   // Sets the pins directly, for reset and strap set-up.
   task automatic pins(input logic c, input logic k, input logic d, input logic e);
      cs_n = c;
      sclk = k;
      sd_o = d;
      sd_en = e;
   endtask
   // One bit: data changes while the clock is low and is taken on the rise.
   task automatic shift(input logic b, input logic drv, output logic got);
      sclk = 1'b0;
      sd_en = drv;
      sd_o = b;
      #80;
      sclk = 1'b1;
      got = sd_line;
      if (dev_oe !== !drv) oe_bad++;
      #80;
   endtask
   // A whole frame; cut is the bit count after which select rises early.
   task automatic xfer(input logic rd, input logic [1:0] wl, input logic [7:0] addr, input int n,
                       input int cut, input logic lsb);
      logic [15:0] ins;
      logic g;
      int pos;
      ins = {rd, wl, 5'h00, addr};
      pos = 0;
      cs_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         shift(lsb ? ins[i] : ins[15 - i], 1'b1, g);
         pos++;
      end
      for (int k = 0; k < n; k++) begin
         for (int j = 0; j < 8; j++) begin
            // Bits past the cut are never sent, which aborts mid-byte.
            if (pos < cut) begin
               shift(tx[k][lsb ? j : 7 - j], !rd, g);
               rx[k][lsb ? j : 7 - j] = g;
               pos++;
            end
         end
      end
      sclk = 1'b0;
      sd_en = 1'b0;
      #80;
      cs_n = 1'b1;
      #160;
   endtask
endmodule

// file: dv/scp_top_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bench for the serial configuration port
// ----------------------------------------------------------------------
module scp_top_test;
   logic clk = 1'b0; // System clock.
   logic rst_n = 1'b0; // Asynchronous reset, active low.
   logic cs_n, sclk, h_o, h_en; // Controller pins.
   logic d_o, d_oe, strap_mode, strap_pattern, strap_powerdown, update_pulse, lsb_first;
   logic [7:0] dev_index; // Device index copy.
   logic float_r = 1'b0; // Toggling level of a released data line.
   wire line; // Resolved data wire.
   int err_count = 0;
   int checks = 0;
   int upd_count = 0; // Transfer pulses seen.
   // The wire never keeps a stale value once both sides let go of it.
   assign line = d_oe ? d_o : (h_en ? h_o : float_r);
   always #5 clk = ~clk;
   // A released line changes every cycle so a stale read cannot pass.
   always @(posedge clk) float_r <= ~line;
   // Counts transfer pulses.
   always @(negedge clk) if (update_pulse === 1'b1) upd_count++;
   scp_host host (.sd_line(line), .dev_oe(d_oe), .cs_n(cs_n), .sclk(sclk), .sd_o(h_o), .sd_en(h_en));
   scp_top DUT (.clk(clk), .rst_n(rst_n), .chip_select_n(cs_n), .serial_clock_pattern_strap(sclk),
      .serial_data_powerdown_strap_i(line), .serial_data_powerdown_strap_o(d_o),
      .serial_data_powerdown_strap_oe(d_oe), .strap_mode(strap_mode), .strap_pattern(strap_pattern),
      .strap_powerdown(strap_powerdown), .dev_index(dev_index), .update_pulse(update_pulse),
      .lsb_first(lsb_first));
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Select low at release means serial mode; high means strap mode.
   task automatic do_reset(input logic c, input logic k);
      host.pins(c, k, 1'b0, 1'b1);
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      if (!c) host.pins(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (4) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input int n, input logic lsb, input int cut);
      @(negedge clk);
      host.xfer(1'b0, (n > 3) ? 2'b11 : 2'(n - 1), a, n, cut, lsb);
   endtask
   task automatic rd(input logic [7:0] a, input int n, input logic lsb);
      @(negedge clk);
      host.xfer(1'b1, 2'(n - 1), a, n, 999, lsb);
      check(8'(d_oe), 8'h00);
   endtask
   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_defaults();
      check(dev_index, 8'h0F);
      check(8'(lsb_first), 8'h00);
      check(8'(strap_mode), 8'h00);
      rd(8'h02, 3, 1'b0);
      check(host.rx[0], 8'h40);
      check(host.rx[1], 8'hA5);
      check(host.rx[2], 8'h18);
      rd(8'h05, 1, 1'b0);
      check(host.rx[0], 8'h0F);
   endtask
   // Streaming write walks the address down; a streaming read returns it.
   task automatic t_stream();
      // The fourth byte lands on an unmapped place, so it carries its default.
      host.tx = '{8'h11, 8'h22, 8'h33, 8'h00};
      wr(8'h0A, 4, 1'b0, 999);
      host.tx[0] = 8'hC3;
      wr(8'h22, 1, 1'b0, 999);
      rd(8'h0A, 4, 1'b0);
      check(host.rx[0], 8'h11);
      check(host.rx[1], 8'h22);
      check(host.rx[2], 8'h33);
      check(host.rx[3], 8'h00);
      rd(8'h22, 1, 1'b0);
      check(host.rx[0], 8'hC3);
      rd(8'h23, 1, 1'b0);
      check(host.rx[0], 8'h00);
   endtask
   task automatic t_index();
      host.tx[0] = 8'h03;
      wr(8'h05, 1, 1'b0, 999);
      check(dev_index, 8'h03);
      host.tx[0] = 8'h01;
      wr(8'hFF, 1, 1'b0, 999);
      check(8'(upd_count), 8'h01);
   endtask
   // Select rises after four data bits; the byte must be dropped.
   task automatic t_abort();
      host.tx[0] = 8'hFF;
      wr(8'h08, 1, 1'b0, 20);
      rd(8'h08, 1, 1'b0);
      check(host.rx[0], 8'h33);
   endtask
   // Bit order flip, incrementing address, then soft reset.
   task automatic t_order();
      host.tx[0] = 8'h42;
      wr(8'h00, 1, 1'b0, 999);
      check(8'(lsb_first), 8'h01);
      host.tx = '{8'h96, 8'h5C, 8'h00, 8'h00};
      wr(8'h08, 2, 1'b1, 999);
      rd(8'h08, 2, 1'b1);
      check(host.rx[0], 8'h96);
      check(host.rx[1], 8'h5C);
      rd(8'h00, 1, 1'b1);
      check(host.rx[0], 8'h5A);
      host.tx[0] = 8'h24;
      wr(8'h00, 1, 1'b1, 999);
      check(8'(lsb_first), 8'h00);
      check(dev_index, 8'h0F);
      rd(8'h00, 1, 1'b0);
      check(host.rx[0], 8'h18);
      rd(8'h08, 1, 1'b0);
      check(host.rx[0], 8'h00);
   endtask
   // Select high at power-up hands the pins to their strap roles.
   task automatic t_strap();
      do_reset(1'b1, 1'b1);
      check(8'(strap_mode), 8'h01);
      check(8'(strap_pattern), 8'h01);
      check(8'(strap_powerdown), 8'h00);
      host.pins(1'b1, 1'b1, 1'b1, 1'b1);
      repeat (6) @(negedge clk);
      check(8'(strap_powerdown), 8'h01);
      host.tx[0] = 8'h00;
      wr(8'h05, 1, 1'b0, 999);
      check(dev_index, 8'h0F);
      do_reset(1'b0, 1'b0);
      check(8'(strap_mode), 8'h00);
   endtask
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      do_reset(1'b0, 1'b0);
      t_defaults();
      t_stream();
      t_index();
      t_abort();
      t_order();
      check(8'(host.oe_bad), 8'h00);
      t_strap();
      stop_test();
   end
endmodule
